// ### rtl/iox_decode.sv
`timescale 1ns/100ps
`default_nettype none
module iox_decode
	import iox_pkg::*;
(
	input wire logic [IOX_INSTR_W-1:0] instr,
	input wire logic instr_valid,
	output iox_sel_t sel,
	output logic dest_file,
	output logic writes_zero,
	output logic skip_on_zero
);
	logic [5:0] op;
	assign op = instr[IOX_OP_HI:IOX_OP_LO];
	always_comb begin
		sel = IOX_SEL_NONE;
		writes_zero = 1'b0;
		skip_on_zero = 1'b0;
		dest_file = 1'b0;
		if (instr_valid) begin
			case (op)
				IOX_INCREMENT_FILE_OP: begin
					sel = IOX_SEL_INC;
					writes_zero = 1'b1;
					dest_file = instr[IOX_DEST_BIT];
				end
				IOX_INCREMENT_SKIP_ZERO_OP: begin
					sel = IOX_SEL_INC;
					skip_on_zero = 1'b1;
					dest_file = instr[IOX_DEST_BIT];
				end
				IOX_OR_ACCUM_FILE_OP: begin
					sel = IOX_SEL_OR_FILE;
					writes_zero = 1'b1;
					dest_file = instr[IOX_DEST_BIT];
				end
				IOX_OR_LITERAL_ACCUM_OP: begin
					sel = IOX_SEL_OR_LIT;
					writes_zero = 1'b1;
				end
				default: begin
					sel = IOX_SEL_NONE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### rtl/iox_exec.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Increment file, result to destination, Z
// - Destination bit: 0 accumulator, 1 file
// - File address is low seven bits
// - OR literal into accumulator, update Z
// - OR accumulator with file, Z updated
// - Increment-skip: no status, skip on zero
module iox_exec
	import iox_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [IOX_INSTR_W-1:0] instr,
	input wire logic instr_valid,
	input wire logic [IOX_DATA_W-1:0] file_rdata,
	output logic [IOX_ADDR_W-1:0] file_addr,
	output logic [IOX_DATA_W-1:0] file_wdata,
	output logic file_we,
	output logic [IOX_DATA_W-1:0] accum,
	output logic zero_flag,
	output logic skip_next,
	output logic done
);
	// Decoded controls
	iox_sel_t sel;
	logic dest_file;
	logic writes_zero;
	logic skip_on_zero;
	logic active;

	// Datapath values
	logic [IOX_DATA_W-1:0] literal;
	logic [IOX_DATA_W-1:0] inc_sum;
	logic [IOX_DATA_W-1:0] or_file_val;
	logic [IOX_DATA_W-1:0] or_lit_val;
	logic [IOX_DATA_W-1:0] result;
	logic result_zero;
	logic to_file;
	logic to_accum;

	// State
	logic [IOX_DATA_W-1:0] accum_reg;
	logic [IOX_DATA_W-1:0] accum_next;
	logic zero_reg;
	logic zero_next;
	logic [IOX_DATA_W-1:0] wdata_reg;
	logic [IOX_DATA_W-1:0] wdata_next;
	logic we_reg;
	logic we_next;
	logic skip_reg;
	logic skip_next_val;
	logic done_reg;
	logic done_next;

	// Opcode decode
	iox_decode u_decode (
		.instr(instr),
		.instr_valid(instr_valid),
		.sel(sel),
		.dest_file(dest_file),
		.writes_zero(writes_zero),
		.skip_on_zero(skip_on_zero)
	);

	assign file_addr = instr[IOX_ADDR_W-1:0];

	// Literal field
	assign literal = instr[IOX_DATA_W-1:0];

	// Supported instruction this cycle
	assign active = (sel != IOX_SEL_NONE);

	assign inc_sum = file_rdata + 8'h01;

	assign or_file_val = accum_reg | file_rdata;

	assign or_lit_val = accum_reg | literal;

	// Result select
	always_comb begin
		result = '0;
		case (sel)
			IOX_SEL_INC: begin
				result = inc_sum;
			end
			IOX_SEL_OR_FILE: begin
				result = or_file_val;
			end
			IOX_SEL_OR_LIT: begin
				result = or_lit_val;
			end
			default: begin
				result = '0;
			end
		endcase
	end

	assign result_zero = (result == 8'h00);

	assign to_file = active && dest_file;
	assign to_accum = active && !dest_file;

	// Accumulator next value
	always_comb begin
		accum_next = accum_reg;
		if (to_accum) begin
			accum_next = result;
		end
	end

	// Accumulator register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			accum_reg <= IOX_ACCUM_RESET;
		end else begin
			accum_reg <= accum_next;
		end
	end

	always_comb begin
		zero_next = zero_reg;
		if (active && writes_zero) begin
			zero_next = result_zero;
		end
	end

	// Zero flag register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_reg <= IOX_ZERO_RESET;
		end else begin
			zero_reg <= zero_next;
		end
	end

	always_comb begin
		wdata_next = wdata_reg;
		we_next = 1'b0;
		if (to_file) begin
			we_next = 1'b1;
			wdata_next = result;
		end
	end

	// File write registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdata_reg <= IOX_WDATA_RESET;
			we_reg <= 1'b0;
		end else begin
			wdata_reg <= wdata_next;
			we_reg <= we_next;
		end
	end

	always_comb begin
		skip_next_val = 1'b0;
		if (active && skip_on_zero && result_zero) begin
			skip_next_val = 1'b1;
		end
	end

	// Skip pulse register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_reg <= 1'b0;
		end else begin
			skip_reg <= skip_next_val;
		end
	end

	always_comb begin
		done_next = 1'b0;
		if (active) begin
			done_next = 1'b1;
		end
	end

	// Done pulse register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
		end
	end

	// Accumulator and status outputs
	assign accum = accum_reg;
	assign zero_flag = zero_reg;

	// File write outputs
	assign file_wdata = wdata_reg;
	assign file_we = we_reg;

	// Pulse outputs
	assign skip_next = skip_reg;
	assign done = done_reg;
endmodule
`default_nettype wire

// ### rtl/iox_pkg.sv
package iox_pkg;
	localparam int IOX_INSTR_W = 14;
	localparam int IOX_DATA_W = 8;
	localparam int IOX_ADDR_W = 7;
	localparam int IOX_DEST_BIT = 7;
	localparam int IOX_OP_HI = 13;
	localparam int IOX_OP_LO = 8;
	localparam logic [5:0] IOX_INCREMENT_FILE_OP = 6'h0a;
	localparam logic [5:0] IOX_INCREMENT_SKIP_ZERO_OP = 6'h0f;
	localparam logic [5:0] IOX_OR_ACCUM_FILE_OP = 6'h04;
	localparam logic [5:0] IOX_OR_LITERAL_ACCUM_OP = 6'h38;
	localparam logic [7:0] IOX_ACCUM_RESET = 8'h00;
	localparam logic [7:0] IOX_WDATA_RESET = 8'h00;
	localparam logic IOX_ZERO_RESET = 1'b0;
	typedef enum logic [1:0] {
		IOX_SEL_NONE,
		IOX_SEL_INC,
		IOX_SEL_OR_FILE,
		IOX_SEL_OR_LIT
	} iox_sel_t;
endpackage

// ### verification/increment_or_instr_exec_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module increment_or_instr_exec_tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0;
	logic [13:0] instr = 14'h0000;
	logic [7:0] file_rdata = 8'h00;
	logic [6:0] file_addr;
	logic [7:0] file_wdata;
	logic file_we;
	logic [7:0] accum;
	logic zero_flag;
	logic skip_next;
	logic done;
	logic [7:0] w = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] r;
	logic z = 1'b0;
	logic [15:0] s = 16'h9d1c;
	logic [18:0] q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	iox_exec DUT (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.instr(instr),
		.instr_valid(instr_valid),
		.file_rdata(file_rdata),
		.file_addr(file_addr),
		.file_wdata(file_wdata),
		.file_we(file_we),
		.accum(accum),
		.zero_flag(zero_flag),
		.skip_next(skip_next),
		.done(done)
	);
	always #2.5 sys_clk=~sys_clk;
	function logic [15:0] lf(logic [15:0] x);
		return {x[14:0],x[15]^x[13]^x[12]^x[10]};
	endfunction
	task complete_run;
		if(n_mismatch==0&&n_tests>0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [18:0] g, input logic [18:0] e);
		n_tests++;
		if(g!==e) begin
			n_mismatch++;
			$display("unexpected %t %h %h",$time,g,e);
		end
	endtask
	always @(negedge sys_clk) begin
		if (done === 1'b1) begin
			chk({accum, zero_flag, file_wdata, file_we, skip_next}, q.pop_front());
		end
	end
	task x(input logic [5:0] p, input logic [7:0] b, input logic [7:0] d);
		@(negedge sys_clk);
		instr_valid = 1'b1;
		instr = {p, b};
		file_rdata = d;
		r = p[1] ? d + 8'h01 : w | (p[5] ? b : d);
		if (p[5] || !b[7]) w = r;
		if (!p[5] && b[7]) wd = r;
		if (!p[0]) z = (r == 8'h00);
		q.push_back({w, z, wd, !p[5] && b[7], p[0] && r == 8'h00});
	endtask
	task y(input logic [5:0] p, input logic [7:0] b, input logic v);
		@(negedge sys_clk);
		instr_valid = v;
		instr = {p, b};
		file_rdata = ~b;
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		x(6'h0a, 8'h85, 8'hff);
		x(6'h0f, 8'h05, 8'hff);
		repeat (200) begin
			s = lf(s);
			x(s[15] ? 6'h04 : s[14] ? 6'h38 : s[13] ? 6'h0a : 6'h0f, s[7:0], ~s[15:8]);
			if (s[3]) y(s[2] ? 6'h3f : 6'h0a, s[11:4], s[2]);
		end
		@(negedge sys_clk);
		instr_valid = 1'b0;
		@(negedge sys_clk);
		chk(19'(q.size()), 19'h00000);
		complete_run;
	end
	initial begin
		#5000 n_mismatch++;
		complete_run;
	end
endmodule
`default_nettype wire

// ### verification/iox_exec_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module iox_chk
	import iox_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [13:0] instr,
	input wire logic [7:0] file_rdata,
	input wire logic [6:0] file_addr,
	input wire logic [7:0] file_wdata,
	input wire logic file_we,
	input wire logic [7:0] accum,
	input wire logic zero_flag,
	input wire logic skip_next,
	input wire logic done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic [5:0] op = instr[13:8];
	wire logic v = instr_valid;
	wire logic [7:0] dst = file_we ? file_wdata : accum;
	sequence s_inc; v && op == IOX_INCREMENT_FILE_OP; endsequence
	sequence s_skp; v && op == IOX_INCREMENT_SKIP_ZERO_OP; endsequence
	sequence s_orf; v && op == IOX_OR_ACCUM_FILE_OP; endsequence
	sequence s_lit; v && op == IOX_OR_LITERAL_ACCUM_OP; endsequence
	sequence s_none;
		!v || (op != IOX_INCREMENT_FILE_OP && op != IOX_INCREMENT_SKIP_ZERO_OP
			&& op != IOX_OR_ACCUM_FILE_OP && op != IOX_OR_LITERAL_ACCUM_OP);
	endsequence
	property p_inc;
		s_inc |=> done && file_we == $past(instr[7]) && dst == $past(file_rdata) + 8'h01 && zero_flag == (dst == 8'h00);
	endproperty
	a_inc: assert property (p_inc) else $error("increment result wrong");
	property p_lit;
		s_lit |=> done && !file_we && accum == ($past(accum) | $past(instr[7:0])) && zero_flag == (accum == 8'h00);
	endproperty
	a_lit: assert property (p_lit) else $error("literal OR result wrong");
	property p_orf;
		s_orf |=> done && file_we == $past(instr[7]) && dst == ($past(accum) | $past(file_rdata)) && zero_flag == (dst == 8'h00);
	endproperty
	a_orf: assert property (p_orf) else $error("file OR result wrong");
	property p_skp;
		s_skp |=> done && file_we == $past(instr[7]) && skip_next == ($past(file_rdata) == 8'hff) && zero_flag == $past(zero_flag);
	endproperty
	a_skp: assert property (p_skp) else $error("increment skip wrong");
	property p_none;
		s_none |=> !done && !file_we && !skip_next && $stable(accum) && $stable(zero_flag);
	endproperty
	a_none: assert property (p_none) else $error("refused instruction acted");
	property p_addr;
		file_addr == instr[6:0];
	endproperty
	a_addr: assert property (p_addr) else $error("file address wrong");
	property p_dst;
		s_inc |=> file_we || accum != $past(accum) || $past(accum) == $past(file_rdata) + 8'h01;
	endproperty
	a_dst: assert property (p_dst) else $error("destination wrong");
endmodule
bind iox_exec iox_chk u_chk (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.instr_valid(instr_valid),
	.instr(instr),
	.file_rdata(file_rdata),
	.file_addr(file_addr),
	.file_wdata(file_wdata),
	.file_we(file_we),
	.accum(accum),
	.zero_flag(zero_flag),
	.skip_next(skip_next),
	.done(done)
);
`default_nettype wire
